// ### core/rtdc_top.sv
// Line transceiver direction control with UART FIFOs and window decode.
//
// Behaviour
// R01 - Four-wire mode keeps transmitter and receiver enabled regardless of DTR or ready.
// R02 - Reset selects four-wire mode.
// R03 - Echo mode enables the transmitter only while active-low DTR is high; receiver stays on.
// R04 - DTR-controlled mode gates the transmitter like echo mode and disables the receiver then.
// R05 - Automatic mode enables the transmitter while transmit-ready is high, else the receiver.
// R06 - Automatic mode switches direction per byte with no software action.
// R07 - The host clears DTR before sending and sets it only after the last bit has left.
// R08 - The host enables the FIFOs whenever it selects automatic mode.
// R09 - One transmit and one receive FIFO exist, both enabled or disabled by one setting.
// R10 - The receive interrupt rises once the receive FIFO count reaches the receive trigger.
// R11 - The transmit trigger sets the largest block written per transmit interrupt.
// R12 - A single-port card decodes an 8-byte window from the port base.
// R13 - A four-port card decodes one 32-byte window covering all ports.
// R14 - A two-port card has a base per port and both ports share one interrupt line.
// R15 - Modes are coded 128 four-wire, 129 echo, 130 DTR-controlled, 131 automatic.
// R16 - Line enables follow mode through one register stage; DTR and ready first pass the three-stage synchroniser and a filter register.
`timescale 1ns/1ps
`default_nettype none
module rtdc_top (
	input  wire logic                        clock,
	input  wire logic                        rstn,
	input  wire logic                        mode_load,
	input  wire logic [7:0]                  mode_code,
	input  wire logic                        fifo_enable,
	input  wire logic [4:0]                  rx_trigger,
	input  wire logic [4:0]                  tx_trigger,
	input  wire logic                        dtr_n,
	input  wire logic                        uart_transmit_ready_line,
	input  wire logic                        tx_wr_valid,
	input  wire logic [rtdc_pkg::DATA_W-1:0] tx_wr_data,
	input  wire logic                        tx_rd_ready,
	input  wire logic                        rx_wr_valid,
	input  wire logic [rtdc_pkg::DATA_W-1:0] rx_wr_data,
	input  wire logic                        rx_rd_ready,
	input  wire logic [1:0]                  card_kind,
	input  wire logic [15:0]                 base0,
	input  wire logic [15:0]                 base1,
	input  wire logic [15:0]                 io_addr,
	input  wire logic                        irq_other_port,
	output logic                             line_tx_en,
	output logic                             line_rx_en,
	output logic [1:0]                       mode_state,
	output logic                             mode_bad,
	output logic                             tx_wr_ready,
	output logic                             tx_rd_valid,
	output logic [rtdc_pkg::DATA_W-1:0]      tx_rd_data,
	output logic                             rx_wr_ready,
	output logic                             rx_rd_valid,
	output logic [rtdc_pkg::DATA_W-1:0]      rx_rd_data,
	output logic                             rx_irq,
	output logic                             tx_irq,
	output logic [4:0]                       tx_block_room,
	output logic                             irq_shared,
	output logic                             addr_hit,
	output logic [1:0]                       addr_port,
	output logic [4:0]                       addr_offset
);
	// ****************************************************************
	// Mode register
	// ****************************************************************
	rtdc_pkg::rtdc_mode_e mode_reg;
	rtdc_pkg::rtdc_mode_e mode_next;
	logic                 bad_reg;
	logic                 bad_next;

	always_comb begin
		mode_next = mode_reg;
		bad_next  = bad_reg;
		if (mode_load) begin
			bad_next = 1'b0;
			case (mode_code) // R15
				rtdc_pkg::MODE_FOUR_WIRE:  mode_next = rtdc_pkg::RTDC_FOUR;
				rtdc_pkg::MODE_DTR_ECHO:   mode_next = rtdc_pkg::RTDC_ECHO;
				rtdc_pkg::MODE_DTR_CTRL:   mode_next = rtdc_pkg::RTDC_DCTRL;
				rtdc_pkg::MODE_AUTO_UART_TRANSMIT_READY_LINE: mode_next = rtdc_pkg::RTDC_AUTO;
				// Unknown codes leave the mode alone and are flagged.
				default:                   bad_next  = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= rtdc_pkg::RTDC_FOUR; // R02
			bad_reg  <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			bad_reg  <= bad_next;
		end
	end

	// ****************************************************************
	// Input synchronisers for UART-side levels
	// ****************************************************************
	// DTR and ready come from the UART core, treated as foreign pins.
	logic [2:0] dtr_sync_reg;
	logic [2:0] rdy_sync_reg;
	logic       dtr_n_reg;
	logic       dtr_n_next;
	logic       rdy_reg;
	logic       rdy_next;

	always_comb begin
		dtr_n_next = (dtr_sync_reg[1] == dtr_sync_reg[2]) ? dtr_sync_reg[2] : dtr_n_reg;
		rdy_next   = (rdy_sync_reg[1] == rdy_sync_reg[2]) ? rdy_sync_reg[2] : rdy_reg;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dtr_sync_reg <= 3'h7;
			rdy_sync_reg <= 3'h0;
			dtr_n_reg    <= 1'b1;
			rdy_reg      <= 1'b0;
		end else begin
			dtr_sync_reg <= {dtr_sync_reg[1:0], dtr_n};
			rdy_sync_reg <= {rdy_sync_reg[1:0], uart_transmit_ready_line};
			dtr_n_reg    <= dtr_n_next;
			rdy_reg      <= rdy_next;
		end
	end

	// ****************************************************************
	// Line enables
	// ****************************************************************
	rtdc_pkg::rtdc_line_s line_reg;
	rtdc_pkg::rtdc_line_s line_next;

	always_comb begin
		case (mode_reg)
			rtdc_pkg::RTDC_FOUR: begin
				line_next.tx_en = 1'b1; // R01
				line_next.rx_en = 1'b1; // R01
			end
			rtdc_pkg::RTDC_ECHO: begin
				line_next.tx_en = dtr_n_reg; // R03
				line_next.rx_en = 1'b1; // R03
			end
			rtdc_pkg::RTDC_DCTRL: begin
				line_next.tx_en = dtr_n_reg; // R04
				line_next.rx_en = !dtr_n_reg; // R04
			end
			rtdc_pkg::RTDC_AUTO: begin
				line_next.tx_en = rdy_reg; // R05 R06
				line_next.rx_en = !rdy_reg; // R05 R06
			end
			default: begin
				line_next.tx_en = 1'b1;
				line_next.rx_en = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			line_reg <= '{tx_en: 1'b1, rx_en: 1'b1};
		end else begin
			line_reg <= line_next; // R16
		end
	end

	// ****************************************************************
	// FIFOs and triggers
	// ****************************************************************
	logic                       tx_ready_w;
	logic                       rx_ready_w;
	logic [rtdc_pkg::FIFO_AW:0] tx_count;
	logic [rtdc_pkg::FIFO_AW:0] rx_count;

	// Both FIFOs share one enable so they can never disagree.
	rtdc_fifo u_tx_fifo (
		.clock    (clock),
		.rstn     (rstn),
		.enable   (fifo_enable), // R09
		.wr_valid (tx_wr_valid),
		.wr_data  (tx_wr_data),
		.wr_ready (tx_ready_w),
		.rd_ready (tx_rd_ready),
		.rd_valid (tx_rd_valid),
		.rd_data  (tx_rd_data),
		.count    (tx_count)
	);

	rtdc_fifo u_rx_fifo (
		.clock    (clock),
		.rstn     (rstn),
		.enable   (fifo_enable), // R09
		.wr_valid (rx_wr_valid && line_reg.rx_en),
		.wr_data  (rx_wr_data),
		.wr_ready (rx_ready_w),
		.rd_ready (rx_rd_ready),
		.rd_valid (rx_rd_valid),
		.rd_data  (rx_rd_data),
		.count    (rx_count)
	);

	assign tx_wr_ready = tx_ready_w;
	assign rx_wr_ready = rx_ready_w;

	logic [4:0] rx_trig_eff;
	logic [4:0] tx_trig_eff;
	logic [4:0] room;
	logic       rx_irq_reg;
	logic       rx_irq_next;
	logic       tx_irq_reg;
	logic       tx_irq_next;
	logic [4:0] blk_reg;
	logic [4:0] blk_next;

	always_comb begin
		// A disabled FIFO behaves as a one-byte buffer with trigger one.
		rx_trig_eff = fifo_enable ? ((rx_trigger == 5'h00) ? 5'h01 : rx_trigger) : 5'h01;
		tx_trig_eff = fifo_enable ? ((tx_trigger == 5'h00) ? 5'h01 : tx_trigger) : 5'h01;
		room        = (fifo_enable ? 5'h10 : 5'h01) - tx_count;
		rx_irq_next = (rx_count >= rx_trig_eff); // R10
		tx_irq_next = (tx_count == 5'h00);
		blk_next    = (room < tx_trig_eff) ? room : tx_trig_eff; // R11
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx_irq_reg <= 1'b0;
			tx_irq_reg <= 1'b0;
			blk_reg    <= 5'h00;
		end else begin
			rx_irq_reg <= rx_irq_next;
			tx_irq_reg <= tx_irq_next;
			blk_reg    <= blk_next;
		end
	end

	// ****************************************************************
	// I/O window decode and shared interrupt
	// ****************************************************************
	function automatic logic in_win(input logic [15:0] a, input logic [15:0] b,
		input logic [7:0] len);
		in_win = (a >= b) && ({1'b0, a} < ({1'b0, b} + {9'h000, len}));
	endfunction

	logic       hit_reg;
	logic       hit_next;
	logic [1:0] port_reg;
	logic [1:0] port_next;
	logic [4:0] off_reg;
	logic [4:0] off_next;
	logic       irq_sh_reg;
	logic       irq_sh_next;
	logic [15:0] diff0;
	logic [15:0] diff1;

	always_comb begin
		diff0     = io_addr - base0;
		diff1     = io_addr - base1;
		hit_next  = 1'b0;
		port_next = 2'h0;
		off_next  = 5'h00;
		case (card_kind)
			rtdc_pkg::CARD_ONE: begin
				hit_next = in_win(io_addr, base0, rtdc_pkg::WIN_ONE_PORT); // R12
				off_next = {2'h0, diff0[2:0]};
			end
			rtdc_pkg::CARD_TWO: begin
				if (in_win(io_addr, base0, rtdc_pkg::WIN_ONE_PORT)) begin // R14
					hit_next = 1'b1;
					off_next = {2'h0, diff0[2:0]};
				end else if (in_win(io_addr, base1, rtdc_pkg::WIN_ONE_PORT)) begin // R14
					hit_next  = 1'b1;
					port_next = 2'h1;
					off_next  = {2'h0, diff1[2:0]};
				end
			end
			rtdc_pkg::CARD_FOUR: begin
				hit_next  = in_win(io_addr, base0, rtdc_pkg::WIN_FOUR_PORT); // R13
				port_next = diff0[4:3];
				off_next  = diff0[4:0];
			end
			default: begin
				hit_next = 1'b0;
			end
		endcase
		// Both ports of a two-port card drive one request line.
		irq_sh_next = rx_irq_next || tx_irq_next ||
			((card_kind == rtdc_pkg::CARD_TWO) && irq_other_port); // R14
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hit_reg    <= 1'b0;
			port_reg   <= 2'h0;
			off_reg    <= 5'h00;
			irq_sh_reg <= 1'b0;
		end else begin
			hit_reg    <= hit_next;
			port_reg   <= port_next;
			off_reg    <= off_next;
			irq_sh_reg <= irq_sh_next;
		end
	end

	assign line_tx_en    = line_reg.tx_en;
	assign line_rx_en    = line_reg.rx_en;
	assign mode_state    = mode_reg;
	assign mode_bad      = bad_reg;
	assign rx_irq        = rx_irq_reg;
	assign tx_irq        = tx_irq_reg;
	assign tx_block_room = blk_reg;
	assign irq_shared    = irq_sh_reg;
	assign addr_hit      = hit_reg;
	assign addr_port     = port_reg;
	assign addr_offset   = off_reg;
endmodule
`default_nettype wire

// ### core/rtdc_pkg.sv
// Package for the line transceiver direction control block.
package rtdc_pkg;

	// Transceiver mode codes as loaded by software.
	localparam logic [7:0] MODE_FOUR_WIRE   = 8'h80;
	localparam logic [7:0] MODE_DTR_ECHO    = 8'h81;
	localparam logic [7:0] MODE_DTR_CTRL    = 8'h82;
	localparam logic [7:0] MODE_AUTO_UART_TRANSMIT_READY_LINE  = 8'h83;
	localparam logic [7:0] MODE_RESET       = MODE_FOUR_WIRE;

	// FIFO geometry and trigger settings.
	localparam int         FIFO_DEPTH       = 16;
	localparam int         FIFO_AW          = 4;
	localparam int         DATA_W           = 8;
	localparam logic [4:0] RX_TRIG_RESET    = 5'h01;
	localparam logic [4:0] TX_TRIG_RESET    = 5'h10;

	// I/O window sizes in bytes and card kind codes.
	localparam logic [7:0] WIN_ONE_PORT     = 8'h08;
	localparam logic [7:0] WIN_FOUR_PORT    = 8'h20;
	localparam logic [1:0] CARD_ONE         = 2'h0;
	localparam logic [1:0] CARD_TWO         = 2'h1;
	localparam logic [1:0] CARD_FOUR        = 2'h2;

	typedef enum logic [1:0] {
		RTDC_FOUR,
		RTDC_ECHO,
		RTDC_DCTRL,
		RTDC_AUTO
	} rtdc_mode_e;

	// Line enables travel together.
	typedef struct packed {
		logic tx_en;
		logic rx_en;
	} rtdc_line_s;

endpackage

// ### core/rtdc_fifo.sv
// Small synchronous FIFO with registered read data.
`timescale 1ns/1ps
`default_nettype none
module rtdc_fifo (
	input  wire logic                        clock,
	input  wire logic                        rstn,
	input  wire logic                        enable,
	input  wire logic                        wr_valid,
	input  wire logic [rtdc_pkg::DATA_W-1:0] wr_data,
	output logic                             wr_ready,
	input  wire logic                        rd_ready,
	output logic                             rd_valid,
	output logic [rtdc_pkg::DATA_W-1:0]      rd_data,
	output logic [rtdc_pkg::FIFO_AW:0]       count
);
	logic [rtdc_pkg::DATA_W-1:0]  mem_reg [rtdc_pkg::FIFO_DEPTH];
	logic [rtdc_pkg::FIFO_AW-1:0] wp_reg;
	logic [rtdc_pkg::FIFO_AW-1:0] wp_next;
	logic [rtdc_pkg::FIFO_AW-1:0] rp_reg;
	logic [rtdc_pkg::FIFO_AW-1:0] rp_next;
	logic [rtdc_pkg::FIFO_AW:0]   cnt_reg;
	logic [rtdc_pkg::FIFO_AW:0]   cnt_next;
	logic [rtdc_pkg::DATA_W-1:0]  dout_reg;
	logic [rtdc_pkg::DATA_W-1:0]  dout_next;
	logic                         dv_reg;
	logic                         dv_next;
	logic [rtdc_pkg::FIFO_AW:0]   occ_reg;
	logic [rtdc_pkg::FIFO_AW:0]   occ_next;
	logic                         rdy_reg;
	logic                         rdy_next;
	logic                         do_wr;
	logic                         do_rd;
	logic                         do_take;

	// With the FIFO disabled the store acts as a single holding byte.
	// Occupancy counts the output register too, so the store never holds more than its
	// depth. Ready is registered, so a change of enable is seen one cycle late.
	logic [rtdc_pkg::FIFO_AW:0] cap;
	assign cap      = enable ? 5'h10 : 5'h01;
	assign wr_ready = rdy_reg;
	assign rd_valid = dv_reg;
	assign rd_data  = dout_reg;
	assign count    = occ_reg;

	always_comb begin
		do_wr     = wr_valid && rdy_reg;
		do_rd     = (cnt_reg != 5'h00) && (!dv_reg || rd_ready);
		do_take   = dv_reg && rd_ready;
		wp_next   = do_wr ? wp_reg + 4'h1 : wp_reg;
		rp_next   = do_rd ? rp_reg + 4'h1 : rp_reg;
		cnt_next  = cnt_reg + {4'h0, do_wr} - {4'h0, do_rd};
		occ_next  = occ_reg + {4'h0, do_wr} - {4'h0, do_take};
		rdy_next  = (occ_next < cap);
		dout_next = do_rd ? mem_reg[rp_reg] : dout_reg;
		dv_next   = do_rd ? 1'b1 : (rd_ready ? 1'b0 : dv_reg);
	end

	always_ff @(posedge clock) begin
		if (do_wr) begin
			mem_reg[wp_reg] <= wr_data;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wp_reg   <= 4'h0;
			rp_reg   <= 4'h0;
			cnt_reg  <= 5'h00;
			dout_reg <= 8'h00;
			dv_reg   <= 1'b0;
			occ_reg  <= 5'h00;
			rdy_reg  <= 1'b1;
		end else begin
			wp_reg   <= wp_next;
			rp_reg   <= rp_next;
			cnt_reg  <= cnt_next;
			dout_reg <= dout_next;
			dv_reg   <= dv_next;
			occ_reg  <= occ_next;
			rdy_reg  <= rdy_next;
		end
	end
endmodule
`default_nettype wire

// ### test/rtdc_checker.sv
// Concurrent checks on the ports of the direction control block.
`timescale 1ns/1ps
`default_nettype none
module rtdc_checker (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        mode_load,
	input wire logic [7:0]  mode_code,
	input wire logic        dtr_n,
	input wire logic        uart_transmit_ready_line,
	input wire logic [1:0]  card_kind,
	input wire logic [15:0] base0,
	input wire logic [15:0] io_addr,
	input wire logic        line_tx_en,
	input wire logic        line_rx_en,
	input wire logic [1:0]  mode_state,
	input wire logic        mode_bad,
	input wire logic        addr_hit
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	a_four_both_on: assert property (mode_state == 2'h0 && $past(mode_state) == 2'h0
		|-> line_tx_en && line_rx_en) else $error("four-wire enable dropped");
	a_echo_rx_on: assert property (mode_state == 2'h1 && $past(mode_state) == 2'h1
		|-> line_rx_en) else $error("echo receiver dropped");
	a_dctrl_excl: assert property (mode_state == 2'h2 && $past(mode_state) == 2'h2
		|-> line_tx_en != line_rx_en) else $error("dtr mode enables not exclusive");
	a_auto_excl: assert property (mode_state == 2'h3 && $past(mode_state) == 2'h3
		|-> line_tx_en != line_rx_en) else $error("auto mode enables not exclusive");
	a_echo_follow: assert property (((mode_state == 2'h1 && $stable(dtr_n))[*6])
		|-> line_tx_en == dtr_n) else $error("echo transmitter not following dtr");
	a_auto_follow: assert property (((mode_state == 2'h3
		&& $stable(uart_transmit_ready_line))[*6]) |-> line_tx_en == uart_transmit_ready_line)
		else $error("auto transmitter not following ready");
	a_mode_load: assert property (mode_load && mode_code[7:2] == 6'h20
		|=> mode_state == $past(mode_code[1:0]) && !mode_bad) else $error("mode not loaded");
	a_bad_code: assert property (mode_load && mode_code[7:2] != 6'h20
		|=> mode_bad && mode_state == $past(mode_state)) else $error("bad code accepted");
	a_window_one: assert property (card_kind == 2'h0 && io_addr - base0 < 16'h0008
		|=> addr_hit) else $error("single window miss");

	c_auto_tx: cover property (mode_state == 2'h3 && line_tx_en);
	c_dctrl_rx: cover property (mode_state == 2'h2 && line_rx_en);
	c_bad: cover property (mode_bad);
endmodule
bind rtdc_top rtdc_checker i_chk (.clock(clock), .rstn(rstn), .mode_load(mode_load),
	.mode_code(mode_code), .dtr_n(dtr_n), .uart_transmit_ready_line(uart_transmit_ready_line),
	.card_kind(card_kind), .base0(base0), .io_addr(io_addr), .line_tx_en(line_tx_en),
	.line_rx_en(line_rx_en), .mode_state(mode_state), .mode_bad(mode_bad), .addr_hit(addr_hit));
`default_nettype wire

// ### test/rtdc_bus_node.sv
// Behavioural far-side bus node that delivers received bytes to the block.
`timescale 1ns/1ps
`default_nettype none
module rtdc_bus_node (
	input  wire logic       clock,
	input  wire logic       go,
	input  wire logic [3:0] n,
	input  wire logic       slow,
	input  wire logic       ready,
	output logic            valid,
	output logic [7:0]      data
);
	// Idle data is inverted so a stale byte never passes for a fresh one.
	initial begin
		valid = 1'b0;
		data = 8'h00;
		forever begin
			@(posedge clock);
			if (go) begin
				for (int i = 0; i < n; i++) begin
					valid <= 1'b1;
					data <= 8'hA0 + 8'(i);
					do @(posedge clock); while (!ready);
					if (slow || i == n - 1) begin
						valid <= 1'b0;
						data <= ~(8'hA0 + 8'(i));
						if (slow) @(posedge clock);
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### test/tb_rtdc_top.sv
// Self-checking testbench for the direction control block.
`timescale 1ns/1ps
`default_nettype none
module tb_rtdc_top;
	logic clock = 1'b0, rstn = 1'b0, mode_load = 1'b0, fifo_enable = 1'b1, dtr_n = 1'b1;
	logic uart_transmit_ready_line = 1'b0, tx_wr_valid = 1'b0, tx_rd_ready = 1'b0;
	logic irq_other_port = 1'b0, go = 1'b0, slow = 1'b0, rx_wr_valid;
	logic rx_rd_ready = 1'b0, rx_rd_valid;
	logic [7:0] mode_code = 8'h80, tx_wr_data = 8'h00, rx_wr_data, tx_rd_data, rx_rd_data;
	logic [4:0] rx_trigger = 5'h01, tx_trigger = 5'h10, tx_block_room, addr_offset;
	logic [3:0] n = 4'h0;
	logic [1:0] card_kind = 2'h3, mode_state, addr_port;
	logic [15:0] base0 = 16'h0000, base1 = 16'h0000, io_addr = 16'h0000;
	logic line_tx_en, line_rx_en, mode_bad, tx_wr_ready, tx_rd_valid, rx_wr_ready;
	logic rx_irq, tx_irq, irq_shared, addr_hit;
	int err_total = 0;
	int tests_run = 0;

	always #5 clock = ~clock;

	rtdc_top i_dut (.clock, .rstn, .mode_load, .mode_code, .fifo_enable, .rx_trigger,
		.tx_trigger, .dtr_n, .uart_transmit_ready_line, .tx_wr_valid, .tx_wr_data,
		.tx_rd_ready, .rx_wr_valid, .rx_wr_data, .rx_rd_ready, .card_kind, .base0,
		.base1, .io_addr, .irq_other_port, .line_tx_en, .line_rx_en, .mode_state, .mode_bad,
		.tx_wr_ready, .tx_rd_valid, .tx_rd_data, .rx_wr_ready, .rx_rd_valid, .rx_rd_data,
		.rx_irq, .tx_irq, .tx_block_room, .irq_shared, .addr_hit, .addr_port, .addr_offset);
	rtdc_bus_node i_node (.clock, .go, .n, .slow, .ready(rx_wr_ready), .valid(rx_wr_valid),
		.data(rx_wr_data));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic set_mode(input logic [7:0] c);
		@(negedge clock);
		mode_load = 1'b1;
		mode_code = c;
		@(negedge clock);
		mode_load = 1'b0;
		repeat (3) @(negedge clock);
	endtask
	task automatic fill(input logic [4:0] depth);
		int k;
		k = 0;
		while (tx_wr_ready === 1'b1 && k < 20) begin
			tx_wr_valid = 1'b1;
			tx_wr_data = 8'(k);
			k++;
			@(negedge clock);
		end
		tx_wr_valid = 1'b0;
		chk("tx depth", depth, 16'(k));
	endtask
	task automatic t_modes();
		logic [1:0] e;
		fifo_enable = 1'b1;
		for (int m = 0; m < 4; m++) begin
			set_mode(8'h80 + 8'(m));
			chk("mode", 16'(m), mode_state);
			for (int p = 0; p < 4; p++) begin
				dtr_n = p[0];
				uart_transmit_ready_line = p[1];
				// Eight cycles cover the three-stage synchroniser, the filter register and the output register.
				repeat (8) @(negedge clock);
				case (m)
					0: e = 2'b11;
					1: e = {p[0], 1'b1};
					2: e = {p[0], !p[0]};
					default: e = {p[1], !p[1]};
				endcase
				chk("line enables", e, {line_tx_en, line_rx_en});
			end
		end
	endtask
	task automatic t_fifo();
		int j;
		tx_trigger = 5'h08;
		@(negedge clock);
		fill(5'h10);
		@(negedge clock);
		chk("room full", 5'h00, tx_block_room);
		tx_rd_ready = 1'b1;
		j = 0;
		// The byte shown now is the one taken at the coming rising edge.
		repeat (40) begin
			if (tx_rd_valid === 1'b1) begin
				chk("tx data", 8'(j), tx_rd_data);
				j++;
			end
			@(negedge clock);
		end
		tx_rd_ready = 1'b0;
		chk("drained", 16'h0010, 16'(j));
		chk("room empty", 5'h08, tx_block_room);
		chk("tx irq", 1'b1, tx_irq);
		fifo_enable = 1'b0;
		@(negedge clock);
		fill(5'h01);
	endtask
	task automatic t_rx();
		int j;
		fifo_enable = 1'b1;
		rx_trigger = 5'h04;
		go = 1'b1;
		n = 4'h3;
		slow = 1'b1;
		@(negedge clock);
		go = 1'b0;
		repeat (12) @(negedge clock);
		chk("rx irq below", 1'b0, rx_irq);
		go = 1'b1;
		n = 4'h1;
		@(negedge clock);
		go = 1'b0;
		repeat (5) @(negedge clock);
		chk("rx irq at", 1'b1, rx_irq);
		rx_rd_ready = 1'b1;
		j = 0;
		repeat (8) begin
			if (rx_rd_valid === 1'b1) begin
				chk("rx data", (j == 3) ? 16'h00A0 : 16'h00A0 + 16'(j), rx_rd_data);
				j++;
			end
			@(negedge clock);
		end
		rx_rd_ready = 1'b0;
		chk("rx drained", 16'h0004, 16'(j));
		chk("rx irq drained", 1'b0, rx_irq);
	endtask
	task automatic t_addr();
		card_kind = 2'h0;
		base0 = 16'h0300;
		io_addr = 16'h0307;
		@(negedge clock);
		chk("hit one", 1'b1, addr_hit);
		io_addr = 16'h0308;
		@(negedge clock);
		chk("miss one", 1'b0, addr_hit);
		card_kind = 2'h2;
		base0 = 16'h0200;
		io_addr = 16'h021F;
		@(negedge clock);
		chk("hit four", 8'hFF, {addr_hit, addr_port, addr_offset});
		io_addr = 16'h0220;
		@(negedge clock);
		chk("miss four", 1'b0, addr_hit);
		chk("shared irq idle", 1'b0, irq_shared);
		card_kind = 2'h1;
		base1 = 16'h0500;
		io_addr = 16'h0503;
		irq_other_port = 1'b1;
		@(negedge clock);
		chk("hit two", 3'h5, {addr_hit, addr_port});
		chk("shared irq", 1'b1, irq_shared);
	endtask

	task automatic t_reset();
		@(negedge clock);
		chk("reset mode", 2'h0, mode_state);
		chk("reset enables", 2'h3, {line_tx_en, line_rx_en});
	endtask
	task automatic t_bad_code();
		set_mode(8'h84);
		chk("bad flag", 1'b1, mode_bad);
		chk("mode kept", 2'h3, mode_state);
		set_mode(8'h80);
	endtask

	initial begin
		repeat (2) @(negedge clock);
		rstn = 1'b1;
		t_reset();
		t_modes();
		t_bad_code();
		t_fifo();
		t_rx();
		t_addr();
		conclude();
	end
	initial begin
		#50000;
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
